// >>> hdl/fes_ctrl.sv
// fes_ctrl: host-side erase sequencer; AXI4-Lite registers in, flash bus pins out.
// assumes one flash bank behind the pins; tri-state of the data bus is resolved outside.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module fes_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [fes_pkg::AXI_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [fes_pkg::AXI_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output fes_pkg::fes_pins_s pinsOut,
	input wire logic [fes_pkg::DQ_W-1:0] dqIn,
	input wire logic readyBusyN
);
	typedef struct packed {
		fes_pkg::fes_state_e st;
		fes_pkg::fes_seq_e seq;
		logic [2:0] step;
		logic [fes_pkg::SHORT_W-1:0] cnt;
		logic [fes_pkg::SECTOR_W-1:0] sector;
		logic [3:0] lastCmd;
		logic [7:0] statusByte;
		logic erasing;
		logic chipMode;
		logic suspended;
		logic err;
		fes_pkg::fes_pins_s pins;
		logic awHeld;
		logic [fes_pkg::AXI_ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} fes_ctrl_state_s;

	fes_ctrl_state_s q;
	fes_ctrl_state_s d;
	logic winLoad, waitLoad, winRun, waitRun, winOpen, rbReady;
	logic [fes_pkg::TIMER_W-1:0] winValue, waitValue;
	logic [fes_pkg::DQ_W:0] syncOut;
	logic doWrite, cmdReq, cmdOk, errSet, errClr, lastStep;
	logic [3:0] cmd;
	logic [31:0] statusWord;

	fes_sync #(.W(fes_pkg::DQ_W + 1)) pinSync (
		.clk(clk),
		.rst(rst),
		.dIn({readyBusyN, dqIn}),
		.dOut(syncOut)
	);

	fes_timer #(.W(fes_pkg::TIMER_W)) windowGuard (
		.clk(clk),
		.rst(rst),
		.load(winLoad),
		.value(winValue),
		.running(winRun)
	);

	fes_timer #(.W(fes_pkg::TIMER_W)) waitTimer (
		.clk(clk),
		.rst(rst),
		.load(waitLoad),
		.value(waitValue),
		.running(waitRun)
	);

	assign rbReady = syncOut[fes_pkg::DQ_W];
	assign winOpen = winRun && q.erasing && !q.chipMode && !q.suspended;

	// one command word: address in the upper bits, data byte below
	function automatic logic [fes_pkg::ADDR_W+7:0] seqWord(fes_pkg::fes_seq_e seq,
		logic [2:0] step, logic [fes_pkg::SECTOR_W-1:0] sector);
		logic [fes_pkg::ADDR_W-1:0] secAddr;
		logic [fes_pkg::ADDR_W-1:0] bankAddr;
		secAddr = {sector, 12'h000};
		bankAddr = {sector[fes_pkg::SECTOR_W-1 -: fes_pkg::BANK_W], 19'h00000};
		seqWord = {fes_pkg::UNLOCK1_ADDR, fes_pkg::CODE_UNLOCK1};
		case (seq)
			fes_pkg::Q_CHIP, fes_pkg::Q_SECTOR: begin
				case (step)
					3'h0, 3'h3: seqWord = {fes_pkg::UNLOCK1_ADDR, fes_pkg::CODE_UNLOCK1};
					3'h1, 3'h4: seqWord = {fes_pkg::UNLOCK2_ADDR, fes_pkg::CODE_UNLOCK2};
					3'h2: seqWord = {fes_pkg::UNLOCK1_ADDR, fes_pkg::CODE_SETUP};
					default: seqWord = (seq == fes_pkg::Q_CHIP) ?
						{fes_pkg::UNLOCK1_ADDR, fes_pkg::CODE_CHIP} :
						{secAddr, fes_pkg::CODE_SECTOR};
				endcase
			end
			fes_pkg::Q_ADD: seqWord = {secAddr, fes_pkg::CODE_SECTOR};
			fes_pkg::Q_SUSPEND: seqWord = {bankAddr, fes_pkg::CODE_SUSPEND};
			fes_pkg::Q_RESUME: seqWord = {bankAddr, fes_pkg::CODE_RESUME};
			fes_pkg::Q_RESET: seqWord = {22'h000000, fes_pkg::CODE_RESET};
			default: seqWord = {fes_pkg::UNLOCK1_ADDR, fes_pkg::CODE_UNLOCK1};
		endcase
	endfunction : seqWord

	// word presented with strobes idle; address set-up before the strobe falls
	function automatic fes_pkg::fes_pins_s present(fes_pkg::fes_seq_e seq, logic [2:0] step,
		logic [fes_pkg::SECTOR_W-1:0] sector);
		logic [fes_pkg::ADDR_W+7:0] w;
		w = seqWord(seq, step, sector);
		present.addr = w[fes_pkg::ADDR_W+7:8];
		present.dqOut = {8'h00, w[7:0]};
		present.dqOe = 1'b1;
		present.ceN = 1'b1;
		present.oeN = 1'b1;
		present.weN = 1'b1;
		present.resetN = 1'b1;
	endfunction : present

	always_comb begin
		statusWord = '0;
		statusWord[fes_pkg::STAT_BUSY] = (q.st != fes_pkg::S_IDLE);
		statusWord[fes_pkg::STAT_WINDOW] = winOpen;
		statusWord[fes_pkg::STAT_SUSPENDED] = q.suspended;
		statusWord[fes_pkg::STAT_ERASING] = q.erasing;
		statusWord[fes_pkg::STAT_CHIP] = q.chipMode;
		statusWord[fes_pkg::STAT_ERROR] = q.err;
		statusWord[fes_pkg::STAT_READY] = rbReady;
		statusWord[fes_pkg::STAT_BYTE_LSB +: 8] = q.statusByte;
	end

	always_comb begin
		d = q;
		winLoad = 1'b0;
		winValue = '0;
		waitLoad = 1'b0;
		waitValue = '0;
		cmdReq = 1'b0;
		errSet = 1'b0;
		errClr = 1'b0;
		cmd = q.wData[3:0];
		lastStep = (q.seq == fes_pkg::Q_CHIP || q.seq == fes_pkg::Q_SECTOR) ?
			(q.step == fes_pkg::LONG_LAST_STEP) : (q.step == 3'h0);
		// write channel: address and data taken in either order
		if (awvalid && !q.awHeld) begin
			d.awHeld = 1'b1;
			d.awAddr = awaddr;
		end
		if (wvalid && !q.wHeld) begin
			d.wHeld = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (q.bValid && bready) begin
			d.bValid = 1'b0;
		end
		doWrite = q.awHeld && q.wHeld && !q.bValid;
		if (doWrite) begin
			d.awHeld = 1'b0;
			d.wHeld = 1'b0;
			d.bValid = 1'b1;
			d.bResp = fes_pkg::RESP_OKAY;
			case (q.awAddr)
				fes_pkg::REG_CMD: begin
					if (q.wStrb[0]) begin
						d.lastCmd = cmd;
						cmdReq = 1'b1;
					end
				end
				fes_pkg::REG_SECTOR: begin
					if (q.wStrb[0]) begin
						d.sector[7:0] = q.wData[7:0];
					end
					if (q.wStrb[1]) begin
						d.sector[9:8] = q.wData[9:8];
					end
				end
				fes_pkg::REG_CLEAR: errClr = q.wStrb[0] && q.wData[0];
				fes_pkg::REG_STATUS: d.bResp = fes_pkg::RESP_OKAY;
				default: d.bResp = fes_pkg::RESP_DECERR;
			endcase
		end
		// read channel
		if (q.rValid && rready) begin
			d.rValid = 1'b0;
		end
		if (arvalid && !q.rValid) begin
			d.rValid = 1'b1;
			d.rResp = fes_pkg::RESP_OKAY;
			case (araddr)
				fes_pkg::REG_CMD: d.rData = {28'h0000000, q.lastCmd};
				fes_pkg::REG_SECTOR: d.rData = {22'h000000, q.sector};
				fes_pkg::REG_STATUS: d.rData = statusWord;
				fes_pkg::REG_CLEAR: d.rData = 32'h00000000;
				default: begin
					d.rData = 32'h00000000;
					d.rResp = fes_pkg::RESP_DECERR;
				end
			endcase
		end
		// which orders the flash may take now; refusals keep the device out of modes
		// that would silently drop the erase set
		case (cmd)
			fes_pkg::CMD_CHIP, fes_pkg::CMD_SECTOR: cmdOk = !q.erasing;
			fes_pkg::CMD_ADD: cmdOk = winOpen;
			fes_pkg::CMD_SUSPEND: cmdOk = q.erasing && !q.chipMode && !q.suspended;
			fes_pkg::CMD_RESUME: cmdOk = q.suspended;
			fes_pkg::CMD_RESET: cmdOk = !q.erasing || q.suspended;
			fes_pkg::CMD_POLL: cmdOk = 1'b1;
			default: cmdOk = 1'b0;
		endcase
		case (q.st)
			fes_pkg::S_IDLE: begin
				if (q.erasing && !q.suspended && !winRun && rbReady) begin
					d.erasing = 1'b0;
					d.chipMode = 1'b0;
				end
			end
			fes_pkg::S_ADDR: begin
				d.pins.ceN = 1'b0;
				d.pins.weN = 1'b0;
				d.cnt = fes_pkg::WE_LOW_CYC;
				d.st = fes_pkg::S_LOW;
			end
			fes_pkg::S_LOW: begin
				d.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h1) begin
					d.pins.weN = 1'b1;
					d.cnt = fes_pkg::WE_HIGH_CYC;
					d.st = fes_pkg::S_HIGH;
					if (lastStep && (q.seq == fes_pkg::Q_SECTOR || q.seq == fes_pkg::Q_ADD)) begin
						winLoad = 1'b1;
						winValue = fes_pkg::WINDOW_CYC;
					end
				end
			end
			fes_pkg::S_HIGH: begin
				d.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h1 && !lastStep) begin
					d.step = q.step + 3'h1;
					d.pins = present(q.seq, q.step + 3'h1, q.sector);
					d.st = fes_pkg::S_ADDR;
				end else if (q.cnt == 4'h1) begin
					d.pins.ceN = 1'b1;
					d.pins.dqOe = 1'b0;
					d.st = fes_pkg::S_IDLE;
					case (q.seq)
						fes_pkg::Q_CHIP, fes_pkg::Q_SECTOR: begin
							d.erasing = 1'b1;
							d.chipMode = (q.seq == fes_pkg::Q_CHIP);
							waitLoad = 1'b1;
							waitValue = fes_pkg::BUSY_CYC;
							d.st = fes_pkg::S_WAIT;
						end
						fes_pkg::Q_SUSPEND: begin
							if (winRun) begin
								winLoad = 1'b1; // window ends at once on suspend
								d.suspended = 1'b1;
							end else begin
								waitLoad = 1'b1;
								waitValue = fes_pkg::SUSPEND_CYC;
								d.st = fes_pkg::S_WAIT;
							end
						end
						fes_pkg::Q_RESUME: begin
							d.suspended = 1'b0;
							waitLoad = 1'b1;
							waitValue = fes_pkg::BUSY_CYC;
							d.st = fes_pkg::S_WAIT;
						end
						default: d.st = fes_pkg::S_IDLE;
					endcase
				end
			end
			fes_pkg::S_READ: begin
				d.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h1) begin
					d.statusByte = syncOut[7:0];
					d.pins.ceN = 1'b1;
					d.pins.oeN = 1'b1;
					d.st = fes_pkg::S_IDLE;
				end
			end
			fes_pkg::S_RESET: begin
				if (!waitRun) begin
					d.pins.resetN = 1'b1;
					waitLoad = 1'b1;
					waitValue = fes_pkg::RESET_READY_CYC;
					d.st = fes_pkg::S_WAIT;
				end
			end
			fes_pkg::S_WAIT: begin
				if (!waitRun) begin
					d.suspended = q.suspended || (q.seq == fes_pkg::Q_SUSPEND);
					d.st = fes_pkg::S_IDLE;
				end
			end
			default: d.st = fes_pkg::S_IDLE;
		endcase
		// new orders; a hardware reset overrides whatever is running
		if (cmdReq && cmd == fes_pkg::CMD_HWRESET) begin
			d.seq = fes_pkg::Q_HWRESET;
			d.pins = present(fes_pkg::Q_RESET, 3'h0, q.sector);
			d.pins.dqOe = 1'b0;
			d.pins.resetN = 1'b0;
			d.erasing = 1'b0;
			d.chipMode = 1'b0;
			d.suspended = 1'b0;
			winLoad = 1'b1;
			winValue = '0;
			waitLoad = 1'b1;
			waitValue = fes_pkg::RESET_PULSE_CYC;
			d.st = fes_pkg::S_RESET;
		end else if (cmdReq && q.st == fes_pkg::S_IDLE && cmdOk && cmd == fes_pkg::CMD_POLL) begin
			d.pins = present(fes_pkg::Q_RESET, 3'h0, q.sector);
			d.pins.addr = {q.sector, 12'h000};
			d.pins.dqOe = 1'b0;
			d.pins.ceN = 1'b0;
			d.pins.oeN = 1'b0;
			d.cnt = fes_pkg::READ_CYC;
			d.st = fes_pkg::S_READ;
		end else if (cmdReq && q.st == fes_pkg::S_IDLE && cmdOk) begin
			case (cmd)
				fes_pkg::CMD_CHIP: d.seq = fes_pkg::Q_CHIP;
				fes_pkg::CMD_SECTOR: d.seq = fes_pkg::Q_SECTOR;
				fes_pkg::CMD_ADD: d.seq = fes_pkg::Q_ADD;
				fes_pkg::CMD_SUSPEND: d.seq = fes_pkg::Q_SUSPEND;
				fes_pkg::CMD_RESUME: d.seq = fes_pkg::Q_RESUME;
				default: d.seq = fes_pkg::Q_RESET;
			endcase
			d.step = 3'h0;
			d.pins = present(d.seq, 3'h0, q.sector);
			d.st = fes_pkg::S_ADDR;
		end else if (cmdReq) begin
			errSet = 1'b1;
		end
		// a refusal in the clearing cycle is kept
		d.err = (q.err && !errClr) || errSet;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.pins.ceN <= 1'b1;
			q.pins.oeN <= 1'b1;
			q.pins.weN <= 1'b1;
			q.pins.resetN <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign awready = !q.awHeld;
	assign wready = !q.wHeld;
	assign bvalid = q.bValid;
	assign bresp = q.bResp;
	assign arready = !q.rValid;
	assign rvalid = q.rValid;
	assign rdata = q.rData;
	assign rresp = q.rResp;
	assign pinsOut = q.pins;

	// strobe count since the engine last left idle, for the checks below
	logic [2:0] strobeCnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobeCnt <= 3'h0;
		end else if (q.st == fes_pkg::S_IDLE) begin
			strobeCnt <= 3'h0;
		end else if ($rose(q.pins.weN)) begin
			strobeCnt <= strobeCnt + 3'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_chip_six: assert property ($rose(q.erasing) && d.chipMode |-> strobeCnt == 3'h6)
		else $error("chip erase not six writes");
	a_sector_six: assert property ($rose(q.erasing) && !q.chipMode |-> strobeCnt == 3'h6)
		else $error("sector erase not six writes");
	a_sector_addr: assert property ($rose(q.pins.weN) && q.seq == fes_pkg::Q_SECTOR
		&& q.step == 3'h5 |-> q.pins.addr[21:12] == q.sector
		&& q.pins.dqOut[7:0] == fes_pkg::CODE_SECTOR)
		else $error("sector address or code wrong");
	a_suspend_bank: assert property ($rose(q.pins.weN) && q.seq == fes_pkg::Q_SUSPEND
		|-> q.erasing && !q.chipMode && q.pins.addr[21:19] == q.sector[9:7]
		&& q.pins.dqOut[7:0] == fes_pkg::CODE_SUSPEND)
		else $error("suspend sent out of place");
	a_resume_gate: assert property ($rose(q.pins.weN) && q.seq == fes_pkg::Q_RESUME
		|-> q.suspended && q.pins.addr[21:19] == q.sector[9:7])
		else $error("resume without suspend");
	a_add_window: assert property ($rose(q.pins.weN) && q.seq == fes_pkg::Q_ADD
		|-> $past(winRun))
		else $error("sector added after guard");
	a_window_cmds: assert property ($fell(q.pins.weN) && winOpen
		|-> q.seq == fes_pkg::Q_ADD || q.seq == fes_pkg::Q_SUSPEND)
		else $error("foreign command in window");
	a_upper_zero: assert property (!q.pins.weN |-> q.pins.dqOe
		&& q.pins.dqOut[15:8] == 8'h00 && !q.pins.ceN)
		else $error("upper data byte driven");
	a_reset_pulse: assert property ($fell(q.pins.resetN) |-> !q.pins.resetN[*8]
		##0 !q.erasing && !q.suspended)
		else $error("reset pulse short or state kept");
	a_bresp_hold: assert property (q.bValid && !bready |=> q.bValid && $stable(q.bResp))
		else $error("write response dropped");

	c_chip_done: cover property ($fell(q.erasing) && $past(q.chipMode));
	c_sector_add: cover property ($rose(q.pins.weN) && q.seq == fes_pkg::Q_ADD);
	c_suspend: cover property ($rose(q.suspended));
	c_resume: cover property ($fell(q.suspended) && q.pins.resetN);
endmodule : fes_ctrl

// >>> hdl/fes_pkg.sv
// fes_pkg: constants, types and pin bundle for the flash erase sequencer host.
// assumes a 25 MHz clock and a NOR flash bank with a 22-bit word address bus.
package fes_pkg;

	// clock and timing, figures in ns, counts derived
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned WE_LOW_NS = 35;
	localparam int unsigned WE_HIGH_NS = 30;
	localparam int unsigned READ_ACCESS_NS = 70;
	localparam int unsigned BUSY_SETTLE_NS = 90;
	localparam int unsigned WINDOW_NS = 80000;
	localparam int unsigned SUSPEND_NS = 20000;
	localparam int unsigned RESET_PULSE_NS = 500;
	localparam int unsigned RESET_READY_NS = 20000;
	localparam int unsigned SYNC_STAGES = 2;
	// cycles lost between the guard load and the next add strobe
	localparam int unsigned WINDOW_MARGIN_CYC = 8;

	localparam int unsigned SHORT_W = 4;
	localparam int unsigned TIMER_W = 12;
	localparam logic [SHORT_W-1:0] WE_LOW_CYC =
		SHORT_W'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [SHORT_W-1:0] WE_HIGH_CYC =
		SHORT_W'((WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [SHORT_W-1:0] READ_CYC =
		SHORT_W'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	localparam logic [TIMER_W-1:0] BUSY_CYC =
		TIMER_W'((BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	// longest time rounds down, less a margin so the add lands strictly inside
	localparam logic [TIMER_W-1:0] WINDOW_CYC =
		TIMER_W'(WINDOW_NS / CLK_PERIOD_NS - WINDOW_MARGIN_CYC);
	localparam logic [TIMER_W-1:0] SUSPEND_CYC =
		TIMER_W'((SUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] RESET_PULSE_CYC =
		TIMER_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] RESET_READY_CYC =
		TIMER_W'((RESET_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// flash addressing and command codes
	localparam int unsigned ADDR_W = 22;
	localparam int unsigned DQ_W = 16;
	localparam int unsigned SECTOR_W = 10;
	localparam int unsigned SECTOR_LSB = 12;
	localparam int unsigned BANK_W = 3;
	localparam int unsigned BANK_LSB = 19;
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002AA;
	localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
	localparam logic [7:0] CODE_SETUP = 8'h80;
	localparam logic [7:0] CODE_CHIP = 8'h10;
	localparam logic [7:0] CODE_SECTOR = 8'h30;
	localparam logic [7:0] CODE_SUSPEND = 8'hB0;
	localparam logic [7:0] CODE_RESUME = 8'h30;
	localparam logic [7:0] CODE_RESET = 8'hF0;
	localparam logic [2:0] LONG_LAST_STEP = 3'h5;

	// software register map
	localparam int unsigned AXI_ADDR_W = 8;
	localparam logic [AXI_ADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] REG_SECTOR = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] REG_CLEAR = 8'h0C;
	localparam logic [3:0] CMD_CHIP = 4'h1;
	localparam logic [3:0] CMD_SECTOR = 4'h2;
	localparam logic [3:0] CMD_ADD = 4'h3;
	localparam logic [3:0] CMD_SUSPEND = 4'h4;
	localparam logic [3:0] CMD_RESUME = 4'h5;
	localparam logic [3:0] CMD_RESET = 4'h6;
	localparam logic [3:0] CMD_HWRESET = 4'h7;
	localparam logic [3:0] CMD_POLL = 4'h8;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_WINDOW = 1;
	localparam int unsigned STAT_SUSPENDED = 2;
	localparam int unsigned STAT_ERASING = 3;
	localparam int unsigned STAT_CHIP = 4;
	localparam int unsigned STAT_ERROR = 5;
	localparam int unsigned STAT_READY = 6;
	localparam int unsigned STAT_BYTE_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_LOW, S_HIGH, S_READ, S_RESET, S_WAIT
	} fes_state_e;

	typedef enum logic [2:0] {
		Q_CHIP, Q_SECTOR, Q_ADD, Q_SUSPEND, Q_RESUME, Q_RESET, Q_HWRESET
	} fes_seq_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DQ_W-1:0] dqOut;
		logic dqOe;
		logic ceN;
		logic oeN;
		logic weN;
		logic resetN;
	} fes_pins_s;

endpackage : fes_pkg

// >>> hdl/fes_sync.sv
// fes_sync: two-flop synchroniser for a bundle of pin inputs.
// assumes each bit is an independent level; words are re-timed bit by bit.
`timescale 1ns/1ps
module fes_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] dIn,
	output logic [W-1:0] dOut
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fes_sync_state_s;

	fes_sync_state_s q;
	fes_sync_state_s d;

	always_comb begin
		d = q;
		d.s1 = dIn;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dOut = q.s2;
endmodule : fes_sync

// >>> hdl/fes_timer.sv
// fes_timer: loadable down-counter; running while the count is non-zero.
// assumes a load of zero is used to stop it early.
`timescale 1ns/1ps
module fes_timer #(
	parameter int unsigned W = 12
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic running
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} fes_timer_state_s;

	fes_timer_state_s q;
	fes_timer_state_s d;

	always_comb begin
		d = q;
		if (load) begin
			d.cnt = value;
		end else if (q.cnt != '0) begin
			d.cnt = q.cnt - W'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign running = (q.cnt != '0);
endmodule : fes_timer

// >>> verification/fes_flash_model.sv
// fes_flash_model: behavioural flash bank answering the host's pin bus.
// assumes pins change only just after clk edges; clk paces internal timers and samples the write strobe.
`timescale 1ns/1ps
module fes_flash_model #(
	parameter int ERASE_CYC = 2500,
	parameter int WIN_CYC = 2000,
	parameter int SUSP_CYC = 300
) (
	input wire logic clk,
	input wire fes_pkg::fes_pins_s pins,
	output logic [15:0] dqIn,
	output logic readyBusyN
);
	logic [119:0] seq = '0;
	logic [19:0] w;
	logic weLast = 1'b1, susp = 1'b0, chip = 1'b0, tgl = 1'b0;
	logic [15:0] last = 16'h0000;
	int busy = 0, win = 0, sw = 0;
	assign w = {pins.addr[11:0], pins.dqOut[7:0]};
	always @(posedge clk) begin
		weLast <= pins.weN;
		tgl <= ~tgl;
		if (!pins.ceN && !pins.oeN) last <= dqIn;
		if (win > 0 && !susp) win <= win - 1;
		else if (busy > 0 && !susp) busy <= busy - 1;
		if (sw == 1) susp <= 1'b1;
		if (sw > 0) sw <= sw - 1;
		if (!pins.resetN) begin
			busy <= 0;
			win <= 0;
			susp <= 1'b0;
			sw <= 0;
		end else if (pins.weN && !weLast && !pins.ceN) begin
			seq <= {seq[99:0], w};
			if (busy > 0 && chip) ;
			else if ({seq[99:0], w} == 120'h555AA_2AA55_55580_555AA_2AA55_55510) begin
				busy <= ERASE_CYC;
				chip <= 1'b1;
			end else if (seq[99:0] == 100'h555AA_2AA55_55580_555AA_2AA55 && w[7:0] == 8'h30 &&
				busy == 0) begin
				win <= WIN_CYC;
				busy <= ERASE_CYC;
				chip <= 1'b0;
			end else if (win > 0 && !susp && w[7:0] == 8'h30) win <= WIN_CYC;
			else if (busy > 0 && !susp && w[7:0] == 8'hB0) begin
				if (win > 0) susp <= 1'b1;
				else sw <= SUSP_CYC;
				win <= 0;
			end else if (susp && w[7:0] == 8'h30) susp <= 1'b0;
			else if (win > 0) begin
				win <= 0;
				busy <= 0;
			end
		end
	end
	// read stays in status while any erase is pending, suspended included
	assign readyBusyN = susp || (busy == 0 && win == 0);
	always_comb begin
		if (!pins.ceN && !pins.oeN && busy > 0)
			dqIn = {8'h00, susp, tgl & !susp, 2'b00, win == 0, tgl, 2'b00};
		else if (!pins.ceN && !pins.oeN) dqIn = 16'hFFFF;
		else dqIn = ~last;
	end
endmodule : fes_flash_model

// >>> verification/testbench.sv
// testbench: drives fes_ctrl over AXI4-Lite against the behavioural flash bank.
// assumes the controller's hand-over latencies; each access queues its expectation.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, readyBusyN;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata, rng = 32'h000006E2;
	logic [1:0] bresp, rresp;
	logic [15:0] dqIn;
	logic [65:0] expQ [$];
	logic [65:0] e;
	logic [33:0] got;
	logic [3:0] bad [3] = '{fes_pkg::CMD_ADD, fes_pkg::CMD_RESUME, 4'hF};
	fes_pkg::fes_pins_s pins;
	int n_fail = 0, checks = 0, cyc = 0;
	fes_ctrl dut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .pinsOut(pins),
		.dqIn(dqIn), .readyBusyN(readyBusyN));
	fes_flash_model flash (.clk(clk), .pins(pins), .dqIn(dqIn), .readyBusyN(readyBusyN));
	initial forever #20 clk = ~clk;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	always @(posedge clk) if (!rst && (rvalid && rready || bvalid && bready)) begin
		e = expQ.pop_front();
		got = rvalid ? {rresp, rdata & e[63:32]} : {bresp, 32'h00000000};
		checks++;
		if (got !== {e[65:64], e[31:0]}) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, {e[65:64], e[31:0]});
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		expQ.push_back({fes_pkg::RESP_OKAY, 64'h0});
		@(posedge clk);
		{awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, v, input logic [1:0] r);
		expQ.push_back({r, m, v});
		@(posedge clk);
		{arvalid, rready, araddr} <= {2'h3, a};
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask : rd
	task automatic st(input logic [31:0] m, v);
		rd(fes_pkg::REG_STATUS, m, v, fes_pkg::RESP_OKAY);
	endtask : st
	task automatic cmd(input logic [3:0] c, input int n);
		wr(fes_pkg::REG_CMD, {28'h0, c});
		repeat (n) @(posedge clk);
	endtask : cmd
	task automatic fault(input logic [3:0] c);
		cmd(c, 2);
		st(32'h00000020, 32'h00000020);
		wr(fes_pkg::REG_CLEAR, 32'h00000001);
	endtask : fault
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// ready bit reaches status only after the two sync flops refill
		repeat (4) @(posedge clk);
		st(32'h0000007F, 32'h00000040);
		rd(8'h10, 32'hFFFFFFFF, 32'h00000000, fes_pkg::RESP_DECERR);
		$display("test reset and map done");
		cmd(fes_pkg::CMD_CHIP, 30);
		st(32'h00000018, 32'h00000018);
		fault(fes_pkg::CMD_SUSPEND);
		while (readyBusyN !== 1'b1) @(posedge clk);
		repeat (8) @(posedge clk);
		st(32'h00000018, 32'h00000000);
		$display("test chip erase done");
		rng = xs(rng);
		wr(fes_pkg::REG_SECTOR, {22'h0, rng[9:0]});
		cmd(fes_pkg::CMD_SECTOR, 30);
		st(32'h0000000E, 32'h0000000A);
		rng = xs(rng);
		wr(fes_pkg::REG_SECTOR, {22'h0, rng[9:0]});
		cmd(fes_pkg::CMD_ADD, 20);
		st(32'h00000020, 32'h00000000);
		cmd(fes_pkg::CMD_SUSPEND, 20);
		st(32'h00000006, 32'h00000004);
		cmd(fes_pkg::CMD_POLL, 20);
		st(32'h00008000, 32'h00008000);
		cmd(fes_pkg::CMD_RESUME, 20);
		st(32'h00000004, 32'h00000000);
		fault(fes_pkg::CMD_RESUME);
		fault(fes_pkg::CMD_CHIP);
		fault(fes_pkg::CMD_RESET);
		cmd(fes_pkg::CMD_POLL, 20);
		st(32'h00008000, 32'h00000000);
		cmd(fes_pkg::CMD_SUSPEND, 20);
		st(32'h00000004, 32'h00000000);
		repeat (500) @(posedge clk);
		st(32'h00000004, 32'h00000004);
		cmd(fes_pkg::CMD_HWRESET, 540);
		st(32'h0000000F, 32'h00000000);
		cmd(fes_pkg::CMD_RESET, 10);
		st(32'h00000021, 32'h00000000);
		$display("test sector erase done");
		foreach (bad[i]) fault(bad[i]);
		$display("test refusals done");
		wrap_up();
	end
endmodule : testbench
